// ### rtl/eeprom_i2c_master.sv
// Function
// [R1] A transmit byte write alone launches a bus transfer.
// [R2] Start, then target address, then the transmit byte.
// [R3] Target address bit 0 picks write (0) or read (1).
// [R4] Writing the transmit byte clears tx_empty_flag, showing busy.
// [R5] After the byte is shifted out tx_empty_flag sets and interrupts.
// [R6] stop_after_write set gives stop after sent byte; clear keeps bus.
// [R7] stop_after_read set gives stop after received byte; clear keeps bus.
// [R8] Software starts a read with read address then a dummy byte.
// [R9] Read start clears rx_full_flag.
// [R10] Received byte latched, then rx_full_flag sets and interrupts.
// [R11] Reading the receive byte clears rx_full_flag.
// [R12] With stop_after_read clear, reception continues without stop.
// [R13] Sequential read: set stop_after_read before the final byte.
// [R14] Random read: dummy write of address bytes, no stop, then read.
// [R15] Word address goes high byte first, low byte second.
// [R16] Byte write: three phases, stop_after_write set before data.
// [R17] Page write: stop_after_write clear across the page data bytes.
// [R18] The memory acknowledges address and word address bytes.
// [R19] End a page by setting stop_after_write before last data byte.
// [R20] Idle leaves both lines released; new transfer waits for stop.
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_master (
  // Clocks and reset
  input  wire logic                             clk,
  input  wire logic                             resetn,
  input  wire logic                             link_clk,
  // Two-wire bus, open drain
  input  wire logic                             scl_in,
  output logic                                  scl_out,
  output logic                                  scl_oe_n,
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe_n,
  // Microcontroller writes and reads
  input  wire logic                             target_address_wr,
  input  wire logic [eeprom_i2c_pkg::BYTE_W-1:0] target_address_data,
  input  wire logic                             tx_byte_wr,
  input  wire logic [eeprom_i2c_pkg::BYTE_W-1:0] tx_byte_data,
  input  wire logic                             rx_byte_rd,
  // Control bits
  input  wire logic                             stop_after_write,
  input  wire logic                             stop_after_read,
  // Status and data
  output logic      [eeprom_i2c_pkg::BYTE_W-1:0] target_address_reg,
  output logic      [eeprom_i2c_pkg::BYTE_W-1:0] rx_byte_reg,
  output logic                                  tx_empty_flag,
  output logic                                  rx_full_flag,
  output logic                                  mcu_irq
);
  import eeprom_i2c_pkg::*;

  // ****************************************
  // Microcontroller side
  // ****************************************
  logic [BYTE_W-1:0] target_address_ff;
  logic [BYTE_W-1:0] tx_byte_ff;
  logic [BYTE_W-1:0] rx_byte_ff;
  logic              addr_new_ff;
  logic              req_restart_ff;
  logic              req_tgl_ff;
  logic              cons_tgl_ff;
  logic              tx_empty_ff;
  logic              rx_full_ff;
  logic              irq_ff;
  logic              done_seen_ff;
  logic              rx_seen_ff;
  logic              done_s;
  logic              rx_s;
  logic              done_evt;
  logic              rx_evt;
  logic              read_launch;

  // Link-side registers read across domains while held stable
  logic              done_tgl_ff;
  logic              rx_tgl_ff;
  logic [BYTE_W-1:0] rx_byte_lk_ff;

  level_sync #(.W(2)) u_back_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({done_tgl_ff, rx_tgl_ff}),
    .q      ({done_s, rx_s})
  );

  assign done_evt    = done_s ^ done_seen_ff;
  assign rx_evt      = rx_s ^ rx_seen_ff;
  assign read_launch = tx_byte_wr && (target_address_ff[DIR_BIT] == DIR_READ);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_seen_ff <= 1'b0;
      rx_seen_ff   <= 1'b0;
    end else begin
      done_seen_ff <= done_s;
      rx_seen_ff   <= rx_s;
    end
  end

  // A new address forces a repeated start on the next launch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      target_address_ff <= ADDR_RST;
      addr_new_ff       <= 1'b0;
    end else begin
      if (target_address_wr) begin
        target_address_ff <= target_address_data;
      end
      if (target_address_wr) begin
        addr_new_ff <= 1'b1;
      end else if (tx_byte_wr) begin
        addr_new_ff <= 1'b0;
      end
    end
  end

  // Request toggle; data stays put until the next transmit byte write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_ff     <= BYTE_RST;
      req_restart_ff <= 1'b0;
      req_tgl_ff     <= 1'b0;
    end else if (tx_byte_wr) begin
      tx_byte_ff     <= tx_byte_data;
      req_restart_ff <= addr_new_ff;
      req_tgl_ff     <= ~req_tgl_ff;                         // [R1]
    end
  end

  // Set wins over clear on both flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_empty_ff <= TX_EMPTY_RST;
    end else if (done_evt) begin
      tx_empty_ff <= 1'b1;                                   // [R5]
    end else if (tx_byte_wr) begin
      tx_empty_ff <= 1'b0;                                   // [R4]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_ff <= RX_FULL_RST;
    end else if (rx_evt) begin
      rx_full_ff <= 1'b1;                                    // [R10]
    end else if (rx_byte_rd || read_launch) begin
      rx_full_ff <= 1'b0;                                    // [R9] [R11]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_byte_ff  <= BYTE_RST;
      cons_tgl_ff <= 1'b0;
    end else begin
      if (rx_evt) begin
        rx_byte_ff <= rx_byte_lk_ff;                         // [R10]
      end
      if (rx_byte_rd) begin
        cons_tgl_ff <= ~cons_tgl_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_evt || rx_evt;                          // [R5] [R10]
    end
  end

  assign target_address_reg = target_address_ff;
  assign rx_byte_reg        = rx_byte_ff;
  assign tx_empty_flag      = tx_empty_ff;
  assign rx_full_flag       = rx_full_ff;
  assign mcu_irq            = irq_ff;

  // ****************************************
  // Link side
  // ****************************************
  link_state_t       st_ff;
  link_state_t       nxt_st;
  logic [1:0]        ph_ff;
  logic [3:0]        bit_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic              addr_phase_ff;
  logic              rd_mode_ff;
  logic              nack_ff;
  logic              req_seen_ff;
  logic              cons_seen_ff;
  logic              scl_oe_n_ff;
  logic              sda_oe_n_ff;
  logic              nxt_scl_oe_n;
  logic              nxt_sda_oe_n;
  logic              pin_low_ff;
  logic              lk_rstn;
  logic              req_s;
  logic              cons_s;
  logic              stop_w_s;
  logic              stop_r_s;
  logic              sda_s;
  logic              scl_s;
  logic              req_new;
  logic              cons_new;
  logic              step;
  logic              bit_end;
  logic              load_tx;

  // Link reset released in step with the link clock
  level_sync #(.W(1)) u_lk_rst (
    .clk    (link_clk),
    .resetn (resetn),
    .d      (1'b1),
    .q      (lk_rstn)
  );

  level_sync #(.W(6)) u_fwd_sync (
    .clk    (link_clk),
    .resetn (lk_rstn),
    .d      ({req_tgl_ff, cons_tgl_ff, stop_after_write, stop_after_read,
              sda_in, scl_in}),
    .q      ({req_s, cons_s, stop_w_s, stop_r_s, sda_s, scl_s})
  );

  assign req_new  = req_s ^ req_seen_ff;
  assign cons_new = cons_s ^ cons_seen_ff;
  // High phase waits for the clock line to be seen high
  assign step     = !((ph_ff == PH_SCL_UP) && !scl_s);
  assign bit_end  = step && (ph_ff == PH_LAST) && (bit_ff == BIT_ACK);
  assign load_tx  = (nxt_st == S_SEND) && !(st_ff == S_START);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: begin
        if (req_new) begin
          nxt_st = S_START;                                  // [R1] [R20]
        end
      end
      S_START: begin
        if (step && (ph_ff == PH_LAST)) begin
          nxt_st = S_SEND;                                   // [R2]
        end
      end
      S_SEND: begin
        if (bit_end) begin
          if (addr_phase_ff) begin
            nxt_st = rd_mode_ff ? S_RECV : S_SEND;           // [R2] [R3]
          end else begin
            nxt_st = stop_w_s ? S_STOP : S_HOLD;             // [R6]
          end
        end
      end
      S_RECV: begin
        if (bit_end) begin
          nxt_st = nack_ff ? S_STOP : S_HOLD;                // [R7] [R12]
        end
      end
      S_HOLD: begin
        if (req_new) begin
          nxt_st = req_restart_ff ? S_START : S_SEND;        // [R14]
        end else if (rd_mode_ff && cons_new) begin
          nxt_st = S_RECV;                                   // [R12]
        end
      end
      S_STOP: begin
        if (step && (ph_ff == PH_LAST)) begin
          nxt_st = S_IDLE;                                   // [R20]
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      st_ff <= S_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      ph_ff  <= 2'h0;
      bit_ff <= 4'h0;
    end else begin
      if ((st_ff != nxt_st) || (st_ff == S_IDLE) || (st_ff == S_HOLD)) begin
        ph_ff <= 2'h0;
      end else if (step) begin
        ph_ff <= ph_ff + 2'h1;
      end
      if (bit_end || (st_ff != nxt_st)) begin
        bit_ff <= 4'h0;
      end else if (step && (ph_ff == PH_LAST)) begin
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end

  // Shift register serves both directions
  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      shift_ff      <= BYTE_RST;
      addr_phase_ff <= 1'b0;
      rd_mode_ff    <= 1'b0;
    end else if ((st_ff == S_START) && (nxt_st == S_SEND)) begin
      shift_ff      <= target_address_ff;                    // [R2]
      addr_phase_ff <= 1'b1;
      rd_mode_ff    <= (target_address_ff[DIR_BIT] == DIR_READ); // [R3]
    end else if (load_tx && ((st_ff != S_SEND) || bit_end)) begin
      shift_ff      <= tx_byte_ff;                           // [R2]
      addr_phase_ff <= 1'b0;
    end else if ((st_ff == S_SEND) && step && (ph_ff == PH_LAST)
                 && (bit_ff != BIT_ACK)) begin
      shift_ff <= {shift_ff[BYTE_W-2:0], 1'b0};
    end else if ((st_ff == S_RECV) && step && (ph_ff == PH_SAMPLE)
                 && (bit_ff != BIT_ACK)) begin
      shift_ff <= {shift_ff[BYTE_W-2:0], sda_s};
    end
  end

  // Acknowledge decided once per received byte
  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      nack_ff <= 1'b0;
    end else if ((st_ff == S_RECV) && (bit_ff == BIT_ACK) && (ph_ff == 2'h0)) begin
      nack_ff <= stop_r_s;                                   // [R7]
    end
  end

  // Request toggles consumed only in idle or hold; consume toggles kept only while a read waits in hold
  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      req_seen_ff  <= 1'b0;
      cons_seen_ff <= 1'b0;
    end else begin
      if (req_new && ((st_ff == S_IDLE) || (st_ff == S_HOLD))) begin
        req_seen_ff <= req_s;
      end
      if (!((st_ff == S_HOLD) && rd_mode_ff && (nxt_st != S_RECV))) begin
        cons_seen_ff <= cons_s;
      end
    end
  end

  // Events back to the microcontroller side
  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      done_tgl_ff   <= 1'b0;
      rx_tgl_ff     <= 1'b0;
      rx_byte_lk_ff <= BYTE_RST;
    end else begin
      if ((st_ff == S_SEND) && bit_end && (!addr_phase_ff || rd_mode_ff)) begin
        done_tgl_ff <= ~done_tgl_ff;                         // [R5]
      end
      if ((st_ff == S_RECV) && bit_end) begin
        rx_tgl_ff     <= ~rx_tgl_ff;                         // [R10]
        rx_byte_lk_ff <= shift_ff;
      end
    end
  end

  // Data changes only while the clock line is low, apart from start and stop
  always_comb begin
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_scl_oe_n = 1'b1;                                 // [R20]
        nxt_sda_oe_n = 1'b1;
      end
      S_START: begin
        case (ph_ff)
          2'h0:    nxt_sda_oe_n = 1'b1;
          2'h1:    nxt_scl_oe_n = 1'b1;
          2'h2:    nxt_sda_oe_n = 1'b0;                      // [R2]
          default: nxt_scl_oe_n = 1'b0;
        endcase
      end
      S_SEND: begin
        case (ph_ff)
          2'h0:    nxt_sda_oe_n = (bit_ff == BIT_ACK) ? 1'b1 : shift_ff[BYTE_W-1];
          2'h1:    nxt_scl_oe_n = 1'b1;
          2'h2:    nxt_scl_oe_n = 1'b1;
          default: nxt_scl_oe_n = 1'b0;
        endcase
      end
      S_RECV: begin
        case (ph_ff)
          2'h0:    nxt_sda_oe_n = (bit_ff == BIT_ACK) ? stop_r_s : 1'b1; // [R7] [R12]
          2'h1:    nxt_scl_oe_n = 1'b1;
          2'h2:    nxt_scl_oe_n = 1'b1;
          default: nxt_scl_oe_n = 1'b0;
        endcase
      end
      S_HOLD: begin
        nxt_scl_oe_n = 1'b0;
        nxt_sda_oe_n = 1'b1;
      end
      S_STOP: begin
        case (ph_ff)
          2'h0:    nxt_sda_oe_n = 1'b0;
          2'h1:    nxt_scl_oe_n = 1'b1;
          2'h2:    nxt_sda_oe_n = 1'b1;                      // [R6] [R7]
          default: nxt_sda_oe_n = 1'b1;
        endcase
      end
      default: begin
        nxt_scl_oe_n = 1'b1;
        nxt_sda_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge lk_rstn) begin
    if (!lk_rstn) begin
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      pin_low_ff  <= 1'b0;
    end else begin
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      pin_low_ff  <= 1'b0;
    end
  end

  assign scl_out  = pin_low_ff;
  assign sda_out  = pin_low_ff;
  assign scl_oe_n = scl_oe_n_ff;
  assign sda_oe_n = sda_oe_n_ff;

  // ****************************************
  // Assertions
  // ****************************************
  tx_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    tx_byte_wr && !done_evt |=> !tx_empty_ff)
    else $error("transmit empty not cleared by byte write");

  tx_set_a: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    done_evt |=> tx_empty_ff && irq_ff)
    else $error("transmit empty or interrupt missing after byte sent");

  rx_set_a: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    rx_evt |=> rx_full_ff && irq_ff && (rx_byte_ff == $past(rx_byte_lk_ff)))
    else $error("received byte not latched with flag");

  rx_clear_a: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    rx_byte_rd && !rx_evt |=> !rx_full_ff)
    else $error("receive full not cleared by read");

  read_start_a: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    read_launch && !rx_evt |=> !rx_full_ff)
    else $error("receive full not cleared at read start");

  launch_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R1]
    (st_ff == S_IDLE) && req_new |=> (st_ff == S_START) ##4 !sda_oe_n_ff)
    else $error("request did not open with start");

  start_order_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R2]
    $fell(sda_oe_n_ff) && scl_oe_n_ff && $past(scl_oe_n_ff) |->
    ($past(st_ff) == S_START))
    else $error("data fell under high clock outside start");

  direction_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R3]
    (st_ff == S_SEND) && addr_phase_ff && bit_end |=>
    (st_ff == (rd_mode_ff ? S_RECV : S_SEND)))
    else $error("direction bit not obeyed");

  write_stop_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R6]
    (st_ff == S_SEND) && !addr_phase_ff && bit_end |=>
    (st_ff == ($past(stop_w_s) ? S_STOP : S_HOLD)))
    else $error("stop after write not obeyed");

  read_more_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R12]
    (st_ff == S_RECV) && bit_end && !nack_ff |=> (st_ff == S_HOLD) && !scl_oe_n_ff)
    else $error("sequential read did not hold bus");

  read_stop_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R7]
    (st_ff == S_RECV) && bit_end && nack_ff |=> (st_ff == S_STOP))
    else $error("stop after read not obeyed");

  idle_free_a: assert property (@(posedge link_clk) disable iff (!lk_rstn) // [R20]
    (st_ff == S_IDLE) && ($past(st_ff) == S_IDLE) |-> sda_oe_n_ff && scl_oe_n_ff)
    else $error("bus not released while idle");

  write_stop_c: cover property (@(posedge link_clk) disable iff (!lk_rstn)
    (st_ff == S_SEND) && !addr_phase_ff && bit_end && stop_w_s);

  read_seq_c: cover property (@(posedge link_clk) disable iff (!lk_rstn)
    (st_ff == S_HOLD) && rd_mode_ff && cons_new);

  restart_c: cover property (@(posedge link_clk) disable iff (!lk_rstn)
    (st_ff == S_HOLD) && req_new && req_restart_ff);

endmodule : eeprom_i2c_master
`default_nettype wire

// ### rtl/eeprom_i2c_pkg.sv
package eeprom_i2c_pkg;

  // ****************************************
  // Data and field layout
  // ****************************************
  localparam int             BYTE_W   = 8;
  localparam int             DIR_BIT  = 0;     // Direction bit of the target address
  localparam logic           DIR_READ = 1'b1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]     ADDR_RST    = 8'h00;
  localparam logic [7:0]     BYTE_RST    = 8'h00;
  localparam logic           TX_EMPTY_RST = 1'b1;
  localparam logic           RX_FULL_RST  = 1'b0;

  // ****************************************
  // Link timing: four phases per bus bit
  // ****************************************
  localparam logic [1:0]     PH_SCL_UP   = 2'h1;
  localparam logic [1:0]     PH_SAMPLE   = 2'h2;
  localparam logic [1:0]     PH_LAST     = 2'h3;
  localparam logic [3:0]     BIT_ACK     = 4'h8; // Ninth bit of every byte

  // ****************************************
  // Link sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_START = 6'h02,
    S_SEND  = 6'h04,
    S_RECV  = 6'h08,
    S_HOLD  = 6'h10,
    S_STOP  = 6'h20
  } link_state_t;

endpackage : eeprom_i2c_pkg

// ### rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= d;
      hold_ff <= meta_ff;
    end
  end

  assign q = hold_ff;

endmodule : level_sync
`default_nettype wire

// ### verification/eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  // Bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Observation
  output logic      [7:0] last_byte,
  output int              n_stop
);
  logic [7:0]  mem [256];
  logic [7:0]  sh;
  logic [15:0] ptr;
  logic        rd, tx, mack, act;
  int          bitn, nb;

  initial begin
    {sda_pull, tx, act, rd, mack} = 5'h00;
    bitn = 0;
    nb = 0;
    n_stop = 0;
    ptr = 16'h0000;
    sh = 8'h00;
    last_byte = 8'h00;
  end

  // ****************
  // Frame edges
  // ****************
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1;
    bitn = 0;
    nb = 0;
    tx = 0;
    sda_pull = 0;
  end
  // Only a frame that opened can close; reset settling is no stop
  always @(posedge sda) if (scl === 1'b1 && act) begin
    act = 0;
    n_stop++;
  end

  // ****************
  // Bit engine
  // ****************
  always @(posedge scl) if (act) begin
    if (bitn == 8) mack = !sda;
    else if (!tx) sh = {sh[6:0], sda};
    bitn++;
  end
  always @(negedge scl) if (act) begin
    if (bitn == 9) begin
      bitn = 0;
      nb++;
      // Master acknowledge keeps the stream going, a release ends it
      tx = rd && (nb == 1 || mack);
      if (tx) begin
        sh = mem[ptr[7:0]];
        ptr++;
      end
      sda_pull = tx && !sh[7];
    end else if (bitn == 8) begin
      sda_pull = !tx;
      if (!tx) begin
        last_byte = sh;
        if (nb == 0) rd = sh[0];
        else if (nb == 1) ptr[15:8] = sh;
        else if (nb == 2) ptr[7:0] = sh;
        else begin
          mem[ptr[7:0]] = sh;
          ptr++;
        end
      end
    end else if (tx) begin
      sh = {sh[6:0], 1'b0};
      sda_pull = !sh[7];
    end
  end
endmodule : eeprom_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eeprom_i2c_pkg::*;
  logic       clk = 0, link_clk = 0, resetn = 0, sda_pull, mcu_irq;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, tx_empty_flag, rx_full_flag;
  logic       target_address_wr = 0, tx_byte_wr = 0, rx_byte_rd = 0;
  logic       stop_after_write = 0, stop_after_read = 0;
  logic [7:0] target_address_data = 8'h00, tx_byte_data = 8'h00;
  logic [7:0] target_address_reg, rx_byte_reg, last_byte;
  int         n_errors = 0, n_checks = 0, n_irq = 0, x_irq = 0, stops = 0, n_stop;
  // Pull-ups on both lines; nobody stretches the clock
  wire logic  scl_in = scl_oe_n;
  wire logic  sda_in = sda_oe_n & ~sda_pull;

  eeprom_i2c_master DUT (.clk, .resetn, .link_clk, .scl_in, .scl_out, .scl_oe_n, .sda_in,
    .sda_out, .sda_oe_n, .target_address_wr, .target_address_data, .tx_byte_wr,
    .tx_byte_data, .rx_byte_rd, .stop_after_write, .stop_after_read, .target_address_reg,
    .rx_byte_reg, .tx_empty_flag, .rx_full_flag, .mcu_irq);
  eeprom_model mem (.scl(scl_in), .sda(sda_in), .sda_pull, .last_byte, .n_stop);

  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  always @(negedge clk) if (mcu_irq === 1'b1) n_irq++;

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic waitf(input int sel);
    int i;
    for (i = 0; i < 5000; i++) begin
      if (sel == 0 && tx_empty_flag === 1'b1) break;
      if (sel == 1 && rx_full_flag === 1'b1) break;
      if (sel == 2 && n_stop == stops) break;
      @(negedge clk);
    end
    if (i == 5000) begin
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
    end
    if (sel < 2) x_irq++;
    repeat (3) @(negedge clk);
  endtask : waitf

  task automatic wr_addr(input logic [7:0] a);
    @(negedge clk);
    target_address_data = a;
    target_address_wr = 1;
    @(negedge clk);
    target_address_wr = 0;
    chk(target_address_reg, a);
  endtask : wr_addr

  task automatic send(input logic [7:0] b, input logic [7:0] seen, input int st);
    @(negedge clk);
    tx_byte_data = b;
    tx_byte_wr = 1;
    @(negedge clk);
    tx_byte_wr = 0;
    chk(tx_empty_flag, 8'h00);
    if (target_address_reg[DIR_BIT] == DIR_READ) chk(rx_full_flag, 8'h00);
    waitf(0);
    chk(last_byte, seen);
    stops += st;
    waitf(2);
    chk(8'(n_stop), 8'(stops));
  endtask : send

  task automatic get(input logic [7:0] exp, input int st, input logic nxt_srd);
    waitf(1);
    chk(rx_byte_reg, exp);
    stop_after_read = nxt_srd;
    @(negedge clk);
    rx_byte_rd = 1;
    @(negedge clk);
    rx_byte_rd = 0;
    chk(rx_full_flag, 8'h00);
    stops += st;
    waitf(2);
    chk(8'(n_stop), 8'(stops));
  endtask : get

  task automatic set_ptr;
    stop_after_write = 0;
    wr_addr(8'ha0);
    send(8'h00, 8'h00, 0);
    send(8'h23, 8'h23, 0);
  endtask : set_ptr

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1;
    chk({tx_empty_flag, rx_full_flag}, 8'h02);
    chk(rx_byte_reg, BYTE_RST);
    chk({scl_oe_n, sda_oe_n}, 8'h03);
    repeat (40) @(negedge clk);
    set_ptr();
    send(8'h5a, 8'h5a, 0);
    stop_after_write = 1;
    send(8'hc3, 8'hc3, 1);
    $display("test page write done");
    set_ptr();
    wr_addr(8'ha1);
    stop_after_read = 1;
    send(8'hff, 8'ha1, 0);
    waitf(1);
    chk(rx_byte_reg, 8'h5a);
    stops += 1;
    waitf(2);
    chk(8'(n_stop), 8'(stops));
    // Left unread so the next read launch has a flag to clear
    chk(rx_full_flag, 8'h01);
    $display("test random read done");
    set_ptr();
    wr_addr(8'ha1);
    stop_after_read = 0;
    send(8'hff, 8'ha1, 0);
    get(8'h5a, 0, 1);
    get(8'hc3, 1, 1);
    chk({scl_oe_n, sda_oe_n}, 8'h03);
    chk({scl_out, sda_out}, 8'h00);
    chk(8'(n_irq), 8'(x_irq));
    $display("test sequential read done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
